/* core/vst_timing_ctrl.sv */
`timescale 1ns/1ps
// Function
// R1 - Horizontal trigger is eleven bits, split registers
// R2 - Host keeps horizontal codes within line limits
// R3 - Higher code shortens delay; 79 aligns hsync
// R4 - Five-bit vertical trigger in half lines
// R5 - Blanking from programmed lines or standard
// R6 - Force blank holds output blanked, reset set
// R7 - Phase reset every two lines, eight/four fields
// R8 - Code zero resets only via enabled realtime input
// R9 - Luma delayed zero to three clocks
// R10 - Field length: interlaced, short, long fields
// R11 - Caption off, odd, even or both fields
// R12 - Teletext enable bit, off after reset
// R13 - Caption line is field plus four/one
// R14 - Second sync start is eleven bits, split
// R15 - Start code 49h aligns with composite sync
// R16 - Hsync source: pin one/embedded or pin two
// R17 - Host avoids undefined field length code 11
module vst_timing_ctrl
  import vst_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,  // Register subaddress
  input wire logic i_reg_wr,  // Write strobe
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,  // Read data, one cycle after address
  input wire logic i_field_freq_select,  // 1 = 60 Hz, 0 = 50 Hz
  input wire logic i_secam,  // SECAM system active
  input wire logic i_hsync_source_select,  // 1 = take hsync from pin two
  input wire logic i_embedded_sync_select,  // 1 = use embedded line sync
  input wire logic i_embedded_sync,  // Decoded embedded line sync
  input wire logic i_sync_pin_one,  // Sync input on pin one
  input wire logic i_vsync_pin_one,  // Vertical sync level on pin one
  input wire logic i_sync_pin_two,  // Sync input on pin two
  input wire logic i_sync2_output_en,  // Pin two switched to output
  input wire logic i_realtime_control_input,  // Phase reset request
  input wire logic i_realtime_control_enable,
  input wire logic [8:0] i_first_active_line,
  input wire logic [8:0] i_last_active_line,
  input wire logic [7:0] i_luma,
  input wire logic [7:0] i_chroma,
  output logic [7:0] o_luma,
  output logic [7:0] o_chroma,
  output logic o_hsync_start,  // Leading slope of output hsync
  output logic o_field_even,
  output logic o_vblank,
  output logic o_blank,  // Output forced to blanking level
  output logic o_sc_phase_reset,  // Subcarrier phase reset pulse
  output logic o_caption_line,  // Current line carries caption data
  output logic [1:0] o_caption_enable,
  output logic o_teletext_enable,
  output logic o_sync_pin_two_out,
  output logic o_sync_pin_two_oe_n  // Low while pin two is driven
);

  // ************************************************************
  // Helpers
  // ************************************************************
  // Wraps a position into the current line length
  function automatic logic [10:0] wrap_pos(input logic [11:0] pos, input logic [10:0] len);
    if (pos >= {1'b0, len}) begin
      wrap_pos = 11'(pos - {1'b0, len});
    end else begin
      wrap_pos = pos[10:0];
    end
  endfunction : wrap_pos

  // Standard dependent caption line offset
  function automatic logic [8:0] cc_offset(input logic m_std);
    cc_offset = m_std ? CC_OFFSET_M : CC_OFFSET_OTHER;
  endfunction : cc_offset

  vst_state_t st;  // Registered state
  vst_state_t next_st;  // Next state

  // Decoded register fields
  logic [10:0] horiz_trigger_phase;
  logic [4:0] vert_trigger_phase;
  logic [10:0] sync2_out_start;
  logic std_vblank_select;
  logic force_blank;
  vst_scrst_t subcarrier_phase_reset_mode;
  logic [1:0] luma_delay;
  vst_flen_t field_length_ctrl;
  logic [1:0] caption_enable;
  logic teletext_enable;
  logic [4:0] caption_line_select;

  // Working terms
  logic [10:0] line_len;
  logic [10:0] half_len;
  logic [9:0] field_half_lines;
  logic [8:0] line_num;
  logic sel_sync;
  logic prev_sel;
  logic trig_edge;
  logic vert_trigger_phase_edge;
  logic line_start;
  logic half_start;
  logic field_end;
  logic [10:0] sync2_pos;

  // ************************************************************
  // Field decode
  // ************************************************************
  always_comb begin
    horiz_trigger_phase = {st.regs.trig_high_vert[HORIZ_HI_LSB +: 3],
                           st.regs.horiz_low};  // R1
    vert_trigger_phase = st.regs.trig_high_vert[VERT_LSB +: 5];  // R4
    sync2_out_start = {st.regs.sync2_high[SYNC2S_HI_LSB +: 3],
                       st.regs.sync2_start_low};  // R14
    std_vblank_select = st.regs.blank_ctrl[STD_VBLANK_BIT];
    force_blank = st.regs.blank_ctrl[FORCE_BLANK_BIT];
    subcarrier_phase_reset_mode = vst_scrst_t'(st.regs.blank_ctrl[SCRST_LSB +: 2]);
    luma_delay = st.regs.blank_ctrl[YDEL_LSB +: 2];
    field_length_ctrl = vst_flen_t'(st.regs.blank_ctrl[FLEN_LSB +: 2]);
    caption_enable = st.regs.caption_ctrl[CCON_LSB +: 2];
    teletext_enable = st.regs.caption_ctrl[TTXON_BIT];
    caption_line_select = st.regs.caption_ctrl[CCLINE_LSB +: 5];
  end

  // ************************************************************
  // Line and field geometry
  // ************************************************************
  always_comb begin
    line_len = i_field_freq_select ? LINE_LEN_60 : LINE_LEN_50;
    half_len = {1'b0, line_len[10:1]};
    // Undefined code runs like the interlaced default
    case (field_length_ctrl)  // R10 R17
      FLEN_SHORT: begin
        field_half_lines = i_field_freq_select ? HALF_LINES_SHORT_60 : HALF_LINES_SHORT_50;
      end
      FLEN_LONG: begin
        field_half_lines = i_field_freq_select ? HALF_LINES_LONG_60 : HALF_LINES_LONG_50;
      end
      default: begin
        field_half_lines = i_field_freq_select ? HALF_LINES_INT_60 : HALF_LINES_INT_50;
      end
    endcase
    line_num = 9'(st.half_line[9:1]) + 9'd1;
    // Embedded sync only used while pin two is not selected
    if (i_hsync_source_select) begin  // R16
      sel_sync = i_sync_pin_two;
      prev_sel = st.prev_sync2;
    end else if (i_embedded_sync_select) begin
      sel_sync = i_embedded_sync;
      prev_sel = st.prev_embedded;
    end else begin
      sel_sync = i_sync_pin_one;
      prev_sel = st.prev_sync1;
    end
    trig_edge = sel_sync & ~prev_sel;
    vert_trigger_phase_edge = i_vsync_pin_one & ~st.prev_sync1;
    line_start = (st.hcount == '0);
    half_start = line_start | (st.hcount == half_len);
    field_end = half_start & (st.half_line == 10'(field_half_lines - 10'd1));
    // Composite sync sits at HSYNC_POS; start code SYNC2_ALIGN lands there
    sync2_pos = wrap_pos(12'({1'b0, sync2_out_start} + {1'b0, HSYNC_POS}
                             + {1'b0, line_len} - {1'b0, SYNC2_ALIGN}), line_len);  // R15
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_st = st;
    // Register writes; reserved bits kept zero
    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_HORIZ_LOW: next_st.regs.horiz_low = i_reg_wdata;  // R1
        ADDR_TRIG_HIGH_VERT: next_st.regs.trig_high_vert = i_reg_wdata;  // R1 R4
        ADDR_BLANK_CTRL: next_st.regs.blank_ctrl = i_reg_wdata;
        ADDR_CAPTION_CTRL: next_st.regs.caption_ctrl = i_reg_wdata;
        ADDR_SYNC2_START_LOW: next_st.regs.sync2_start_low = i_reg_wdata;  // R14
        ADDR_SYNC2_HIGH: next_st.regs.sync2_high = i_reg_wdata & SYNC2_HIGH_MASK;  // R14
        default: begin
          // Other subaddresses belong elsewhere
        end
      endcase
    end
    // Read mux, unmapped subaddresses read zero
    case (i_reg_addr)
      ADDR_HORIZ_LOW: next_st.rdata = st.regs.horiz_low;
      ADDR_TRIG_HIGH_VERT: next_st.rdata = st.regs.trig_high_vert;
      ADDR_BLANK_CTRL: next_st.rdata = st.regs.blank_ctrl;
      ADDR_CAPTION_CTRL: next_st.rdata = st.regs.caption_ctrl;
      ADDR_SYNC2_START_LOW: next_st.rdata = st.regs.sync2_start_low;
      ADDR_SYNC2_HIGH: next_st.rdata = st.regs.sync2_high;
      default: next_st.rdata = 8'h00;
    endcase

    // Edge history
    next_st.prev_sync1 = i_sync_pin_one;
    next_st.prev_sync2 = i_sync_pin_two;
    next_st.prev_embedded = i_embedded_sync;

    // Horizontal counter; trigger loads the code so a larger code reaches
    // the sync position sooner, code 79 landing on the trigger cycle
    if (trig_edge) begin
      next_st.hcount = wrap_pos({1'b0, horiz_trigger_phase}, line_len);  // R3
    end else if (st.hcount >= 11'(line_len - 11'd1)) begin
      next_st.hcount = '0;
    end else begin
      next_st.hcount = 11'(st.hcount + 11'd1);
    end

    // Half line counter and field sequence
    if (vert_trigger_phase_edge) begin
      next_st.half_line = {5'd0, vert_trigger_phase};  // R4
    end else if (field_end) begin
      next_st.half_line = '0;
      next_st.field_even = ~st.field_even;
      next_st.field_cnt = 3'(st.field_cnt + 3'd1);
    end else if (half_start) begin
      next_st.half_line = 10'(st.half_line + 10'd1);
    end
    if (line_start) begin
      next_st.line_pair = ~st.line_pair;
    end

    // Vertical blanking
    if (std_vblank_select) begin  // R5
      next_st.vblank = i_field_freq_select
                       ? (line_num < STD_VBL_END_60) || (line_num > STD_VBL_LAST_60)
                       : (line_num < STD_VBL_END_50) || (line_num > STD_VBL_LAST_50);
    end else begin
      next_st.vblank = (line_num < i_first_active_line) || (line_num > i_last_active_line);
    end
    // Force blank overrides everything
    next_st.blank = force_blank | next_st.vblank;  // R6

    // Subcarrier phase reset cadence
    case (subcarrier_phase_reset_mode)  // R7 R8
      SCRST_TWO_LINES: begin
        // SECAM resets on every line start
        next_st.sc_reset = line_start & (i_secam | ~st.line_pair);
      end
      SCRST_EIGHT_FIELDS: next_st.sc_reset = field_end & (st.field_cnt == 3'd7);
      SCRST_FOUR_FIELDS: next_st.sc_reset = field_end & (st.field_cnt[1:0] == 2'd3);
      default: next_st.sc_reset = i_realtime_control_input & i_realtime_control_enable;
    endcase

    // Luma against chroma delay
    next_st.luma_d1 = i_luma;
    next_st.luma_d2 = st.luma_d1;
    next_st.luma_d3 = st.luma_d2;
    next_st.video_out.chroma = i_chroma;
    case (luma_delay)  // R9
      2'd1: next_st.video_out.luma = st.luma_d1;
      2'd2: next_st.video_out.luma = st.luma_d2;
      2'd3: next_st.video_out.luma = st.luma_d3;
      default: next_st.video_out.luma = i_luma;
    endcase

    // Caption line match per enabled field
    next_st.caption_line = (line_num == 9'({4'd0, caption_line_select}
                                           + cc_offset(i_field_freq_select)))  // R13
                           & (st.field_even ? caption_enable[1] : caption_enable[0]);  // R11

    // Timing pulses
    next_st.hsync_start = (st.hcount == HSYNC_POS);  // R3
    next_st.sync2_pulse = (st.hcount == sync2_pos);  // R14 R15
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.regs.horiz_low <= RST_HORIZ_LOW;
      st.regs.trig_high_vert <= RST_TRIG_HIGH_VERT;
      st.regs.blank_ctrl <= RST_BLANK_CTRL;  // R6
      st.regs.caption_ctrl <= RST_CAPTION_CTRL;  // R11 R12
      st.regs.sync2_start_low <= RST_SYNC2_START_LOW;
      st.regs.sync2_high <= RST_SYNC2_HIGH;
      st.blank <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  always_comb begin
    o_reg_rdata = st.rdata;
    o_luma = st.video_out.luma;
    o_chroma = st.video_out.chroma;
    o_hsync_start = st.hsync_start;
    o_field_even = st.field_even;
    o_vblank = st.vblank;
    o_blank = st.blank;
    o_sc_phase_reset = st.sc_reset;
    o_caption_line = st.caption_line;
    o_caption_enable = caption_enable;
    o_teletext_enable = teletext_enable;  // R12
    o_sync_pin_two_out = st.sync2_pulse & i_sync2_output_en;
    o_sync_pin_two_oe_n = ~i_sync2_output_en;
  end

endmodule : vst_timing_ctrl

/* core/vst_pkg.sv */
package vst_pkg;

  // ************************************************************
  // Register subaddresses
  // ************************************************************
  localparam logic [7:0] ADDR_HORIZ_LOW = 8'h6c;  // Horizontal trigger, low byte
  localparam logic [7:0] ADDR_TRIG_HIGH_VERT = 8'h6d;  // Trigger high bits, vertical trigger
  localparam logic [7:0] ADDR_BLANK_CTRL = 8'h6e;  // Blanking, phase reset, delay, field
  localparam logic [7:0] ADDR_CAPTION_CTRL = 8'h6f;  // Caption and teletext
  localparam logic [7:0] ADDR_SYNC2_START_LOW = 8'h70;  // Second sync pin start, low byte
  localparam logic [7:0] ADDR_SYNC2_HIGH = 8'h72;  // Second sync pin high bits

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int HORIZ_HI_LSB = 5;  // Trigger bits 10:8 in bits 7:5
  localparam int VERT_LSB = 0;  // Vertical trigger in bits 4:0
  localparam int STD_VBLANK_BIT = 7;
  localparam int FORCE_BLANK_BIT = 6;
  localparam int SCRST_LSB = 4;
  localparam int YDEL_LSB = 2;
  localparam int FLEN_LSB = 0;
  localparam int CCON_LSB = 6;
  localparam int TTXON_BIT = 5;
  localparam int CCLINE_LSB = 0;
  localparam int SYNC2S_HI_LSB = 0;  // Start bits 10:8 in bits 2:0
  localparam logic [7:0] SYNC2_HIGH_MASK = 8'h77;  // Bits 7 and 3 reserved, read zero

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_HORIZ_LOW = 8'h00;
  localparam logic [7:0] RST_TRIG_HIGH_VERT = 8'h00;
  localparam logic [7:0] RST_BLANK_CTRL = 8'h40;  // Force blank set
  localparam logic [7:0] RST_CAPTION_CTRL = 8'h00;
  localparam logic [7:0] RST_SYNC2_START_LOW = 8'h00;
  localparam logic [7:0] RST_SYNC2_HIGH = 8'h00;

  // ************************************************************
  // Timing constants, in clock cycles, half lines and lines
  // ************************************************************
  localparam logic [10:0] LINE_LEN_50 = 11'd1728;
  localparam logic [10:0] LINE_LEN_60 = 11'd1716;
  localparam logic [10:0] HSYNC_POS = 11'h04f;  // Leading slope of output hsync
  localparam logic [10:0] SYNC2_ALIGN = 11'h049;  // Start code aligned with hsync
  localparam logic [9:0] HALF_LINES_INT_50 = 10'd625;
  localparam logic [9:0] HALF_LINES_INT_60 = 10'd525;
  localparam logic [9:0] HALF_LINES_SHORT_50 = 10'd624;
  localparam logic [9:0] HALF_LINES_SHORT_60 = 10'd524;
  localparam logic [9:0] HALF_LINES_LONG_50 = 10'd626;
  localparam logic [9:0] HALF_LINES_LONG_60 = 10'd526;
  localparam logic [8:0] STD_VBL_END_50 = 9'd23;  // First active line, 50 Hz
  localparam logic [8:0] STD_VBL_END_60 = 9'd20;  // First active line, 60 Hz
  localparam logic [8:0] STD_VBL_LAST_50 = 9'd310;
  localparam logic [8:0] STD_VBL_LAST_60 = 9'd262;
  localparam logic [8:0] CC_OFFSET_M = 9'd4;
  localparam logic [8:0] CC_OFFSET_OTHER = 9'd1;

  // ************************************************************
  // Mode encodings
  // ************************************************************
  typedef enum logic [1:0] {
    SCRST_NONE = 2'b00,
    SCRST_TWO_LINES = 2'b01,
    SCRST_EIGHT_FIELDS = 2'b10,
    SCRST_FOUR_FIELDS = 2'b11
  } vst_scrst_t;

  typedef enum logic [1:0] {
    FLEN_INTERLACED = 2'b00,
    FLEN_SHORT = 2'b01,
    FLEN_LONG = 2'b10,
    FLEN_UNDEFINED = 2'b11
  } vst_flen_t;

  // Register file image
  typedef struct packed {
    logic [7:0] horiz_low;
    logic [7:0] trig_high_vert;
    logic [7:0] blank_ctrl;
    logic [7:0] caption_ctrl;
    logic [7:0] sync2_start_low;
    logic [7:0] sync2_high;
  } vst_regs_t;

  // Video sample pair travelling through the delay path
  typedef struct packed {
    logic [7:0] luma;
    logic [7:0] chroma;
  } vst_video_t;

  // Whole block state
  typedef struct packed {
    vst_regs_t regs;
    logic [7:0] rdata;
    logic [10:0] hcount;
    logic [9:0] half_line;
    logic field_even;
    logic [2:0] field_cnt;
    logic line_pair;
    logic prev_sync1;
    logic prev_sync2;
    logic prev_embedded;
    logic [7:0] luma_d1;
    logic [7:0] luma_d2;
    logic [7:0] luma_d3;
    vst_video_t video_out;
    logic hsync_start;
    logic vblank;
    logic blank;
    logic sc_reset;
    logic caption_line;
    logic sync2_pulse;
  } vst_state_t;

endpackage : vst_pkg

/* sim/vst_sync_src_model.sv */
`timescale 1ns/1ps
// ************************************************************
// External sync source, one pulse per request
// ************************************************************
module vst_sync_src_model (
  input wire logic i_core_clk,
  input wire logic i_fire,  // Each toggle asks for one pulse
  input wire logic [1:0] i_pin,  // 0 pin one, 1 embedded, 2 pin two
  output logic o_sync_pin_one,
  output logic o_sync_pin_two,
  output logic o_embedded_sync
);
  logic fire_q = 1'b0;  // Last request level seen
  logic [3:0] width_cnt = 4'h0;  // Cycles left in the pulse
  logic [1:0] pin_q = 2'b00;  // Pin carrying the pulse
  // Toggle request avoids a strobe that must fall mid-task
  always_ff @(posedge i_core_clk) begin
    fire_q <= i_fire;
    if (i_fire != fire_q) begin
      width_cnt <= 4'h8;
      pin_q <= i_pin;
    end else if (width_cnt != 4'h0) begin
      width_cnt <= width_cnt - 4'h1;
    end
  end
  // Idle pins sit low, so only the chosen pin shows a rising edge
  assign o_sync_pin_one = (width_cnt != 4'h0) && (pin_q == 2'd0);
  assign o_embedded_sync = (width_cnt != 4'h0) && (pin_q == 2'd1);
  assign o_sync_pin_two = (width_cnt != 4'h0) && (pin_q == 2'd2);
endmodule : vst_sync_src_model

/* sim/vst_timing_ctrl_props.sv */
`timescale 1ns/1ps
// ************************************************************
// Port checker for the timing control block
// ************************************************************
module vst_timing_ctrl_props (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_chroma,
  input wire logic i_sync2_output_en,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [7:0] o_chroma,
  input wire logic o_hsync_start,
  input wire logic o_vblank,
  input wire logic o_blank,
  input wire logic [1:0] o_caption_enable,
  input wire logic o_teletext_enable,
  input wire logic o_sync_pin_two_out,
  input wire logic o_sync_pin_two_oe_n
);
  // One clock domain, so one default clocking
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  logic unmapped;  // Address outside the register map
  assign unmapped = (i_reg_addr < 8'h6c) || (i_reg_addr == 8'h71) || (i_reg_addr > 8'h72);
  oe_level_a: assert property (o_sync_pin_two_oe_n == !i_sync2_output_en)
    else $error("pin two enable level wrong");
  sync2_gate_a: assert property (o_sync_pin_two_out |-> i_sync2_output_en || $past(i_sync2_output_en))
    else $error("pin two pulse while input");
  sync2_single_a: assert property (o_sync_pin_two_out |=> !o_sync_pin_two_out)
    else $error("pin two pulse too long");
  hsync_single_a: assert property (o_hsync_start |=> !o_hsync_start)
    else $error("hsync pulse too long");
  chroma_path_a: assert property (!$past(i_rst) |-> o_chroma == $past(i_chroma))
    else $error("chroma latency wrong");
  blank_reset_a: assert property ($fell(i_rst) |-> o_blank)
    else $error("blank not set after reset");
  blank_vblank_a: assert property (o_vblank && $past(o_vblank) |-> o_blank)
    else $error("vblank not blanked");
  rdata_unmapped_a: assert property ($past(unmapped) |-> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_reserved_a: assert property ($past(i_reg_addr) == 8'h72 |-> (o_reg_rdata & 8'h88) == 8'h00)
    else $error("reserved bits not zero");
  ttx_write_a: assert property ($changed(o_teletext_enable) |-> $past(i_reg_wr) && $past(i_reg_addr) == 8'h6f)
    else $error("teletext enable moved alone");
  cc_write_a: assert property ($changed(o_caption_enable) |-> $past(i_reg_wr) && $past(i_reg_addr) == 8'h6f)
    else $error("caption enable moved alone");
endmodule : vst_timing_ctrl_props
bind vst_timing_ctrl vst_timing_ctrl_props props_u (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_chroma(i_chroma), .i_sync2_output_en(i_sync2_output_en), .o_reg_rdata(o_reg_rdata),
  .o_chroma(o_chroma), .o_hsync_start(o_hsync_start), .o_vblank(o_vblank), .o_blank(o_blank),
  .o_caption_enable(o_caption_enable), .o_teletext_enable(o_teletext_enable),
  .o_sync_pin_two_out(o_sync_pin_two_out), .o_sync_pin_two_oe_n(o_sync_pin_two_oe_n)
);

/* sim/vst_timing_ctrl_test.sv */
`timescale 1ns/1ps
// ************************************************************
// Self-checking bench for the timing control block
// ************************************************************
module vst_timing_ctrl_test import vst_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, hz60 = 1'b0, secam = 1'b0, src2 = 1'b0, emb = 1'b0;
  logic s2_en = 1'b0, rt_in = 1'b0, rt_en = 1'b0, fire = 1'b0;
  logic [1:0] pin = 2'b00;
  logic [7:0] addr = 8'h00, wdata = 8'h00, luma = 8'h00, chroma = 8'h00, d, v;
  logic sync1, sync2, esync, hs, feven, vbl, blk, scr, ccl, tte, s2o, s2oe_n;
  logic [7:0] rdata, y_out, c_out;
  logic [1:0] cce;
  logic [3:0][7:0] lh = '0;  // Luma as sampled, newest first
  int seed = 79, err_count = 0, n_checks = 0, cyc = 0, d0, n, per;
  // Map, reset values, write masks keeping codes legal, read masks
  logic [7:0] ra [7] = '{8'h6c, 8'h6d, 8'h6e, 8'h6f, 8'h70, 8'h72, 8'h71};
  logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wm [7] = '{8'hff, 8'h5f, 8'hfd, 8'hff, 8'hff, 8'h53, 8'hff};
  logic [7:0] rm [7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h77, 8'h00};
  int gs [4] = '{0, 100, 256, 4000};  // Expected pin two lag behind hsync
  always #25 clk = ~clk;
  // Random video every cycle, history, and the run ceiling
  always @(posedge clk) begin
    luma <= 8'($random(seed));
    chroma <= 8'($random(seed));
    lh <= {lh[2:0], luma};
    cyc++;
    if (cyc == 95000) begin
      err_count++;
      report_and_stop();
    end
  end
  vst_timing_ctrl dut_u (.i_core_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_field_freq_select(hz60), .i_secam(secam),
    .i_hsync_source_select(src2), .i_embedded_sync_select(emb), .i_embedded_sync(esync),
    .i_sync_pin_one(sync1), .i_vsync_pin_one(sync1), .i_sync_pin_two(sync2),
    .i_sync2_output_en(s2_en), .i_realtime_control_input(rt_in),
    .i_realtime_control_enable(rt_en), .i_first_active_line(9'h000),
    .i_last_active_line(9'h1ff), .i_luma(luma), .i_chroma(chroma), .o_luma(y_out),
    .o_chroma(c_out), .o_hsync_start(hs), .o_field_even(feven), .o_vblank(vbl), .o_blank(blk),
    .o_sc_phase_reset(scr), .o_caption_line(ccl), .o_caption_enable(cce),
    .o_teletext_enable(tte), .o_sync_pin_two_out(s2o), .o_sync_pin_two_oe_n(s2oe_n));
  vst_sync_src_model src_u (.i_core_clk(clk), .i_fire(fire), .i_pin(pin),
    .o_sync_pin_one(sync1), .o_sync_pin_two(sync2), .o_embedded_sync(esync));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic step(inout int c);
    @(posedge clk);
    #1;
    c++;
  endtask : step
  // Write strobe held one edge; next write comes two edges later
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] dv);
    @(posedge clk);
    addr <= a;
    wr <= 1'b1;
    wdata <= dv;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stands one edge after the address is taken
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    @(posedge clk);
    #1;
    q = rdata;
  endtask : rd_reg
  task automatic set_pair(input logic [7:0] lo, input logic [7:0] hi, input logic [10:0] c);
    wr_reg(lo, c[7:0]);
    wr_reg(hi, (hi == 8'h6d) ? {c[10:8], 5'h00} : {5'h00, c[10:8]});
  endtask : set_pair
  function automatic logic probe(input int s);
    return (s == 0) ? hs : (s == 1) ? s2o : scr;
  endfunction : probe
  // Cycles from a sync request to the hsync pulse
  task automatic fire_delay(input logic [1:0] p, output int c);
    @(posedge clk);
    fire <= ~fire;
    pin <= p;
    c = 0;
    step(c);
    while (hs !== 1'b1 && c < 4000) step(c);
  endtask : fire_delay
  // Cycles from a pulse on one output to the next pulse on the same or another output
  task automatic gap(input int a, input int b, output int c);
    c = 0;
    while (probe(a) !== 1'b1 && c < 4000) step(c);
    c = 0;
    if (a == b) step(c);
    while (probe(b) !== 1'b1 && c < 4000) step(c);
  endtask : gap
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd_reg(ra[i], d);
      chk(d, rv[i], "reset value");
    end
    chk(blk, 1'b1, "blank after reset");
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h80 : (i == 1) ? 8'h00 : 8'h40;
      wr_reg(8'h6e, v);
      repeat (3) @(posedge clk);
      #1;
      chk(vbl, v[7], "vblank select");
      chk(blk, v[7] | v[6], "blank level");
    end
    for (int i = 0; i < 7; i++) begin
      v = 8'($random(seed)) & wm[i];
      wr_reg(ra[i], v);
      rd_reg(ra[i], d);
      chk(d, v & rm[i], "readback");
    end
    $display("Test done: registers");
    for (int k = 0; k < 4; k++) begin
      v = {k[1:0], 6'($random(seed))};
      wr_reg(8'h6f, v);
      repeat (2) @(posedge clk);
      #1;
      chk(cce, v[7:6], "caption enable");
      chk(tte, v[5], "teletext enable");
      wr_reg(8'h6d, {3'h0, v[3:0], k[0]});
      fire <= ~fire;
      repeat (3) @(posedge clk);
      #1;
      chk({feven, ccl}, {1'b0, ~v[4] & k[0]}, "caption line");
      wr_reg(8'h6e, {4'h0, k[1:0], 2'b00});
      repeat (3) @(posedge clk);
      for (int j = 0; j < 6; j++) begin
        step(n);
        chk(y_out, lh[k], "luma delay");
      end
    end
    $display("Test done: enables and luma delay");
    for (int f = 0; f < 2; f++) begin
      hz60 <= f[0];
      set_pair(8'h6c, 8'h6d, HSYNC_POS);
      fire_delay(2'd0, d0);
      chk(d0 inside {[3:4]}, 1'b1, "hsync aligned to trigger");
      gap(0, 0, per);
      chk(per, f ? LINE_LEN_60 : LINE_LEN_50, "line period");
      set_pair(8'h6c, 8'h6d, HSYNC_POS - 11'd20);
      fire_delay(2'd0, n);
      chk(n, d0 + 20, "lower code delays more");
      set_pair(8'h6c, 8'h6d, HSYNC_POS + 11'h100);
      fire_delay(2'd0, n);
      chk(n, (f ? LINE_LEN_60 : LINE_LEN_50) - 256 + d0, "high trigger bits");
    end
    set_pair(8'h6c, 8'h6d, HSYNC_POS - 11'd20);
    for (int s = 0; s < 3; s++) begin
      src2 <= (s == 2);
      emb <= (s == 1);
      fire_delay(s[1:0], n);
      chk(n, d0 + 20, "selected source triggers");
      gap(0, 0, per);
      fire_delay(2'((s + 1) % 3), n);
      chk(n != d0 + 20, 1'b1, "other source ignored");
    end
    $display("Test done: horizontal trigger");
    for (int i = 0; i < 4; i++) begin
      s2_en <= (i != 3);
      set_pair(8'h70, 8'h72, SYNC2_ALIGN + 11'(gs[i] % 4000));
      gap(0, 0, n);
      gap(0, 1, n);
      chk(n, gs[i], "pin two start");
    end
    $display("Test done: pin two pulse");
    hz60 <= 1'b0;
    rt_in <= 1'b1;
    wr_reg(8'h6e, 8'h00);
    n = 0;
    for (int j = 0; j < 20; j++) begin
      step(per);
      n += scr;
    end
    chk(n, 0, "no reset while disabled");
    rt_en <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(scr, 1'b1, "realtime reset");
    rt_en <= 1'b0;
    rt_in <= 1'b0;
    wr_reg(8'h6e, 8'h10);
    for (int s = 0; s < 2; s++) begin
      secam <= s[0];
      gap(2, 2, n);
      gap(2, 2, n);
      chk(n, s ? LINE_LEN_50 : 2 * LINE_LEN_50, "phase reset cadence");
    end
    $display("Test done: phase reset");
    report_and_stop();
  end
endmodule : vst_timing_ctrl_test
